// *** src/jlss_pkg.sv ***
package jlss_pkg;
   // -----------------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // -----------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IDS = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CFG0 = 8'h0c;
   localparam logic [7:0] ADDR_CFG1 = 8'h10;
   localparam logic [7:0] ADDR_CFG2 = 8'h14;
   localparam logic [7:0] ADDR_CHK = 8'h18;
   localparam logic [31:0] UNMAPPED_VAL = 32'hdeadbeef;

   // -----------------------------------------------------------------------
   // Control register fields
   // -----------------------------------------------------------------------
   localparam int CTRL_SCR_BIT = 0;
   localparam int CTRL_ALERT_BIT = 1;
   localparam int CTRL_TWO_LANE_BIT = 2;
   localparam int CTRL_SUBCL_LSB = 4;
   localparam int CTRL_K_LSB = 8;
   localparam int CTRL_TMO_LSB = 16;
   localparam logic [2:0] SUBCL_RESET = 3'h1;
   localparam logic [4:0] K_RESET = 5'h1f;
   localparam logic [7:0] TMO_RESET = 8'h04;
   localparam logic [7:0] DID_RESET = 8'h00;
   localparam logic [3:0] BID_RESET = 4'h0;

   // -----------------------------------------------------------------------
   // Fixed link parameters
   // -----------------------------------------------------------------------
   localparam logic [4:0] L1_ONE = 5'h00;
   localparam logic [4:0] L1_TWO = 5'h01;
   localparam logic [4:0] LID_B = 5'h01;
   localparam logic [7:0] F1_ONE = 8'h03;
   localparam logic [7:0] F1_TWO = 8'h01;
   localparam logic [7:0] M1_VAL = 8'h01;
   localparam logic [1:0] CS_VAL = 2'h1;
   localparam logic [4:0] N1_VAL = 5'h0d;
   localparam logic [4:0] NP1_VAL = 5'h0f;
   localparam logic [2:0] JESDV_VAL = 3'h1;
   localparam logic [4:0] S1_VAL = 5'h00;
   localparam logic HD_VAL = 1'b0;
   localparam logic [4:0] CF_VAL = 5'h00;

   // -----------------------------------------------------------------------
   // Sync timing
   // -----------------------------------------------------------------------
   localparam int SYNC_DETECT_LFC_EDGES = 5;
   localparam int OCTETS_PER_CYCLE = 1;

   // Link states.
   typedef enum logic [3:0] {
      JLSS_DATA = 4'b0001,
      JLSS_WAIT = 4'b0010,
      JLSS_CGS = 4'b0100,
      JLSS_HOLD = 4'b1000
   } jlss_link_t;
endpackage

// *** src/jlss_skid.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer: a receiver stall never drops a word.
module jlss_skid #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   logic [W-1:0] mem_r [2];
   logic rd_r;
   logic wr_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;

   // Handshakes are honest full and empty.
   assign in_ready_out = (cnt_r != 2'h2);
   assign out_valid_out = (cnt_r != 2'h0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem_r[rd_r];

   // Storage and pointers.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wr_r] <= in_data_in;
            wr_r <= ~wr_r;
         end
         if (pop) begin
            rd_r <= ~rd_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // jlss_skid
`default_nettype wire

// *** src/jlss_top.sv ***
// Operation
// [R1] Receiver drives active-low sync request.
// [R2] Receiver must match all link parameters.
// [R3] Counts reported minus one, fixed values.
// [R4] Checksum is field sum modulo 256.
// [R5] Subclass 0 performs no clock alignment.
// [R6] Subclass 1 SYSREF rise resets frame timing.
// [R7] Alert mode ignores first SYSREF pulse.
// [R8] First pulse arms, next pulse resets.
// [R9] Timeout in multiframes disarms alert logic.
// [R10] Subclass 2 samples sync release edge.
// [R11] Subclass 2 release realigns frame clocks.
// [R12] Release resolved to one device clock.
// [R13] Identifiers and options software writable.
// [R14] Fixed control, density, version values reported.
// [R15] Sync detected fifth frame edge, K28.5 follows.
// [R16] Subclass 1 holds K28.5 to multiframe.
// [R17] Subclass 2 resets frame, multiframe clocks.
`timescale 1ns/1ps
`default_nettype none
module jlss_top #(
   parameter int FRAME_CYCLES = 4
) (
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   // Link pins
   input wire logic SYNC_N_IN,
   input wire logic SYSREF_IN,
   // Sample stream in
   input wire logic SAMPLE_VALID_IN,
   output logic SAMPLE_READY_OUT,
   input wire logic [7:0] SAMPLE_DATA_IN,
   // Lane octet stream out
   output logic LANE_VALID_OUT,
   input wire logic LANE_READY_IN,
   output logic [7:0] LANE_DATA_OUT,
   output logic LANE_K_OUT,
   // Timing markers
   output logic FRAME_START_OUT,
   output logic MFRAME_START_OUT,
   // Avalon-MM slave
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT
);
   initial begin
      if (FRAME_CYCLES < 1 || FRAME_CYCLES > 256) begin
         $error("FRAME_CYCLES out of range");
      end
   end

   // -----------------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------------
   logic sync_m_r, sync_s_r, sync_d_r;
   logic sref_m_r, sref_s_r, sref_d_r;

   // Two flops before any logic; the third stage feeds edge detection.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         sync_m_r <= 1'b1;
         sync_s_r <= 1'b1;
         sync_d_r <= 1'b1;
         sref_m_r <= 1'b0;
         sref_s_r <= 1'b0;
         sref_d_r <= 1'b0;
      end else begin
         sync_m_r <= SYNC_N_IN; // see [R1]
         sync_s_r <= sync_m_r;
         sync_d_r <= sync_s_r;
         sref_m_r <= SYSREF_IN;
         sref_s_r <= sref_m_r;
         sref_d_r <= sref_s_r;
      end
   end

   // Edges are seen on one device clock edge, so resolution is one period.
   logic sync_rise, sref_rise;
   assign sync_rise = sync_s_r && !sync_d_r; // see [R10] see [R12]
   assign sref_rise = sref_s_r && !sref_d_r; // see [R6]

   // -----------------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------------
   logic scr_r, alert_r, two_lane_r;
   logic [2:0] subcl_r;
   logic [4:0] k1_r;
   logic [7:0] tmo_r, did_r;
   logic [3:0] bid_r;
   logic wr_hit;
   assign wr_hit = AVS_WRITE_IN;

   // Software writable link options, byte lane gated.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         scr_r <= 1'b0;
         alert_r <= 1'b0;
         two_lane_r <= 1'b1;
         subcl_r <= jlss_pkg::SUBCL_RESET;
         k1_r <= jlss_pkg::K_RESET;
         tmo_r <= jlss_pkg::TMO_RESET;
         did_r <= jlss_pkg::DID_RESET;
         bid_r <= jlss_pkg::BID_RESET;
      end else if (wr_hit && AVS_ADDRESS_IN == jlss_pkg::ADDR_CTRL) begin
         if (AVS_BYTEENABLE_IN[0]) begin
            scr_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_SCR_BIT]; // see [R13]
            alert_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_ALERT_BIT];
            two_lane_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_TWO_LANE_BIT];
            subcl_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_SUBCL_LSB +: 3];
         end
         if (AVS_BYTEENABLE_IN[1]) begin
            k1_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_K_LSB +: 5];
         end
         if (AVS_BYTEENABLE_IN[2]) begin
            tmo_r <= AVS_WRITEDATA_IN[jlss_pkg::CTRL_TMO_LSB +: 8];
         end
      end else if (wr_hit && AVS_ADDRESS_IN == jlss_pkg::ADDR_IDS) begin
         if (AVS_BYTEENABLE_IN[0]) begin
            did_r <= AVS_WRITEDATA_IN[7:0]; // see [R13]
         end
         if (AVS_BYTEENABLE_IN[1]) begin
            bid_r <= AVS_WRITEDATA_IN[11:8];
         end
      end
   end

   // -----------------------------------------------------------------------
   // Link parameter fields and checksum
   // -----------------------------------------------------------------------
   logic [4:0] l1_val;
   logic [7:0] f1_val;
   logic [7:0] fchk;
   // Counts are reported as value minus one.
   assign l1_val = two_lane_r ? jlss_pkg::L1_TWO : jlss_pkg::L1_ONE; // see [R3]
   assign f1_val = two_lane_r ? jlss_pkg::F1_TWO : jlss_pkg::F1_ONE; // see [R3]

   // Checksum of lane zero; wraps naturally in eight bits.
   always_comb begin
      fchk = did_r + {4'h0, bid_r} + {7'h0, scr_r} + {3'h0, l1_val} + f1_val; // see [R4]
      fchk = fchk + {3'h0, k1_r} + jlss_pkg::M1_VAL + {6'h0, jlss_pkg::CS_VAL}; // see [R14]
      fchk = fchk + {3'h0, jlss_pkg::N1_VAL} + {5'h0, subcl_r};
      fchk = fchk + {3'h0, jlss_pkg::NP1_VAL} + {5'h0, jlss_pkg::JESDV_VAL};
      fchk = fchk + {3'h0, jlss_pkg::S1_VAL} + {7'h0, jlss_pkg::HD_VAL};
      fchk = fchk + {3'h0, jlss_pkg::CF_VAL};
   end

   // -----------------------------------------------------------------------
   // Frame and multiframe timing
   // -----------------------------------------------------------------------
   logic [7:0] fcnt_r;
   logic [4:0] mcnt_r;
   logic frame_end, mf_end, clk_reset;
   logic armed_r;
   logic [7:0] arm_cnt_r;
   logic sref_align;
   assign frame_end = (fcnt_r == 8'(FRAME_CYCLES - 1));
   assign mf_end = frame_end && (mcnt_r == k1_r);

   // Alert mode: first pulse arms, a later pulse while armed aligns.
   assign sref_align = (subcl_r == 3'h1) && sref_rise && (!alert_r || armed_r); // see [R7]
   // Subclass 0 aligns nothing; subclass 2 aligns on sync release.
   assign clk_reset = sref_align || ((subcl_r == 3'h2) && sync_rise); // see [R5] see [R11]

   // Local frame and multiframe counters.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         fcnt_r <= 8'h00;
         mcnt_r <= 5'h00;
      end else if (clk_reset) begin
         fcnt_r <= 8'h00; // see [R6] see [R17]
         mcnt_r <= 5'h00;
      end else if (frame_end) begin
         fcnt_r <= 8'h00;
         mcnt_r <= mf_end ? 5'h00 : mcnt_r + 5'h01;
      end else begin
         fcnt_r <= fcnt_r + 8'h01;
      end
   end

   // Arm state with multiframe timeout.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         armed_r <= 1'b0;
         arm_cnt_r <= 8'h00;
      end else if (!alert_r || subcl_r != 3'h1) begin
         armed_r <= 1'b0;
         arm_cnt_r <= 8'h00;
      end else if (sref_rise) begin
         armed_r <= !armed_r; // see [R8]
         arm_cnt_r <= 8'h00;
      end else if (armed_r && mf_end) begin
         if (arm_cnt_r + 8'h01 >= tmo_r) begin
            armed_r <= 1'b0; // see [R9]
            arm_cnt_r <= 8'h00;
         end else begin
            arm_cnt_r <= arm_cnt_r + 8'h01;
         end
      end
   end

   // -----------------------------------------------------------------------
   // Synchronisation state machine
   // -----------------------------------------------------------------------
   jlss_pkg::jlss_link_t st_r;
   logic [2:0] low_edges_r;
   logic sync_low;
   assign sync_low = !sync_s_r;

   // Count frame clock edges while the request is held low.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         low_edges_r <= 3'h0;
      end else if (!sync_low) begin
         low_edges_r <= 3'h0;
      end else if (frame_end && low_edges_r != 3'(jlss_pkg::SYNC_DETECT_LFC_EDGES)) begin
         low_edges_r <= low_edges_r + 3'h1;
      end
   end

   logic detect;
   assign detect = sync_low && frame_end &&
      (low_edges_r == 3'(jlss_pkg::SYNC_DETECT_LFC_EDGES - 1)); // see [R15]

   // Link state: data, wait for frame or multiframe boundary, code groups, hold.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st_r <= jlss_pkg::JLSS_CGS;
      end else begin
         unique case (st_r)
            jlss_pkg::JLSS_DATA: begin
               if (detect) begin
                  st_r <= jlss_pkg::JLSS_CGS; // see [R15]
               end
            end
            jlss_pkg::JLSS_CGS: begin
               // The release edge shows up in the very cycle that ends CGS.
               if (!sync_low && subcl_r == 3'h2 && sync_rise) begin
                  st_r <= jlss_pkg::JLSS_HOLD; // see [R17]
               end else if (!sync_low) begin
                  st_r <= jlss_pkg::JLSS_WAIT;
               end
            end
            jlss_pkg::JLSS_WAIT: begin
               if (subcl_r == 3'h0 && frame_end) begin
                  st_r <= jlss_pkg::JLSS_DATA;
               end else if (subcl_r == 3'h2 && sync_rise) begin
                  st_r <= jlss_pkg::JLSS_HOLD;
               end else if (subcl_r != 3'h0 && mf_end) begin
                  st_r <= jlss_pkg::JLSS_DATA; // see [R16]
               end
            end
            jlss_pkg::JLSS_HOLD: begin
               if (mf_end) begin
                  st_r <= jlss_pkg::JLSS_DATA;
               end
            end
            default: st_r <= jlss_pkg::JLSS_CGS;
         endcase
      end
   end

   // -----------------------------------------------------------------------
   // Output path through two-entry buffer
   // -----------------------------------------------------------------------
   logic send_k, src_valid, src_ready;
   logic [8:0] src_word, out_word;
   assign send_k = (st_r != jlss_pkg::JLSS_DATA);
   // K28.5 is octet bc with the control flag set.
   assign src_word = send_k ? {1'b1, 8'hbc} : {1'b0, SAMPLE_DATA_IN};
   assign src_valid = send_k || SAMPLE_VALID_IN;
   assign SAMPLE_READY_OUT = src_ready && !send_k;

   jlss_skid #(
      .W(9)
   ) u_buf (
      .clk_in(CLOCK_IN),
      .nrst_in(NRST_IN),
      .in_valid_in(src_valid),
      .in_ready_out(src_ready),
      .in_data_in(src_word),
      .out_valid_out(LANE_VALID_OUT),
      .out_ready_in(LANE_READY_IN),
      .out_data_out(out_word)
   );
   assign LANE_DATA_OUT = out_word[7:0];
   assign LANE_K_OUT = out_word[8];

   // Registered timing markers.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         FRAME_START_OUT <= 1'b0;
         MFRAME_START_OUT <= 1'b0;
      end else begin
         FRAME_START_OUT <= frame_end || clk_reset;
         MFRAME_START_OUT <= mf_end || clk_reset;
      end
   end

   // -----------------------------------------------------------------------
   // Avalon read path, zero wait states
   // -----------------------------------------------------------------------
   assign AVS_WAITREQUEST_OUT = 1'b0;
   always_comb begin
      AVS_READDATA_OUT = 32'h0;
      unique case (AVS_ADDRESS_IN)
         jlss_pkg::ADDR_CTRL: AVS_READDATA_OUT = {8'h0, tmo_r, 3'h0, k1_r, 1'b0, subcl_r,
            1'b0, two_lane_r, alert_r, scr_r};
         jlss_pkg::ADDR_IDS: AVS_READDATA_OUT = {20'h0, bid_r, did_r};
         jlss_pkg::ADDR_STATUS: AVS_READDATA_OUT = {19'h0, mcnt_r, armed_r, 3'h0, st_r};
         jlss_pkg::ADDR_CFG0: AVS_READDATA_OUT = {3'h0, k1_r, f1_val, 3'h0, l1_val,
            8'h0};
         jlss_pkg::ADDR_CFG1: AVS_READDATA_OUT = {3'h0, jlss_pkg::NP1_VAL, 5'h0, subcl_r,
            3'h0, jlss_pkg::N1_VAL, jlss_pkg::CS_VAL, 6'h0};
         jlss_pkg::ADDR_CFG2: AVS_READDATA_OUT = {3'h0, jlss_pkg::CF_VAL, 7'h0,
            jlss_pkg::HD_VAL, 3'h0, jlss_pkg::S1_VAL, 5'h0, jlss_pkg::JESDV_VAL};
         jlss_pkg::ADDR_CHK: AVS_READDATA_OUT = {24'h0, fchk}; // see [R4]
         default: AVS_READDATA_OUT = jlss_pkg::UNMAPPED_VAL;
      endcase
   end
endmodule // jlss_top
`default_nettype wire

// *** sim/jlss_top_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module jlss_top_checker #(
   parameter int FRAME_CYCLES = 4
) (
   // Clock, reset and link pins
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic SYNC_N_IN,
   input wire logic SYSREF_IN,
   // Lane side and markers
   input wire logic LANE_VALID_OUT,
   input wire logic LANE_READY_IN,
   input wire logic [7:0] LANE_DATA_OUT,
   input wire logic LANE_K_OUT,
   input wire logic FRAME_START_OUT,
   input wire logic MFRAME_START_OUT,
   // Register bus
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   input wire logic [31:0] AVS_READDATA_OUT,
   input wire logic AVS_WAITREQUEST_OUT
);
   // Detection plus buffer drain, so stale data words are gone by then.
   localparam int SYNC_WAIT = 6 * FRAME_CYCLES + 12;
   logic [2:0] subcl_r;
   logic alert_r;
   int ready_run_r;
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!NRST_IN);
   // Bus writes are snooped so the checks know which alignment mode is live.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         subcl_r <= jlss_pkg::SUBCL_RESET;
         alert_r <= 1'b0;
      end else if (AVS_WRITE_IN && AVS_ADDRESS_IN == jlss_pkg::ADDR_CTRL && AVS_BYTEENABLE_IN[0]) begin
         subcl_r <= AVS_WRITEDATA_IN[6:4];
         alert_r <= AVS_WRITEDATA_IN[1];
      end
   end
   // Counts ready cycles under a held request; saturates to stay small.
   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ready_run_r <= 0;
      end else if (SYNC_N_IN) begin
         ready_run_r <= 0;
      end else if (LANE_READY_IN && ready_run_r < 1000) begin
         ready_run_r <= ready_run_r + 1;
      end
   end
   sequence s_clock_reset;
      ##[2:6] (FRAME_START_OUT && MFRAME_START_OUT);
   endsequence
   property p_k_code;
      LANE_VALID_OUT && LANE_K_OUT |-> LANE_DATA_OUT == 8'hbc;
   endproperty
   a_k_code: assert property (p_k_code) else $error("comma word has wrong octet");
   property p_sync_k;
      ready_run_r >= SYNC_WAIT && LANE_VALID_OUT && LANE_READY_IN |-> LANE_K_OUT;
   endproperty
   a_sync_k: assert property (p_sync_k) else $error("data sent under request");
   property p_sc1_align;
      subcl_r == 3'h1 && !alert_r && $rose(SYSREF_IN) |-> s_clock_reset;
   endproperty
   a_sc1_align: assert property (p_sc1_align) else $error("no realign on ref pulse");
   property p_sc2_align;
      subcl_r == 3'h2 && $rose(SYNC_N_IN) |-> s_clock_reset;
   endproperty
   a_sc2_align: assert property (p_sc2_align) else $error("no realign on release");
   property p_mf_frame;
      MFRAME_START_OUT |-> FRAME_START_OUT;
   endproperty
   a_mf_frame: assert property (p_mf_frame) else $error("multiframe off frame edge");
   property p_hold;
      LANE_VALID_OUT && !LANE_READY_IN |=>
         LANE_VALID_OUT && $stable(LANE_DATA_OUT) && $stable(LANE_K_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("lane word dropped in stall");
   property p_no_wait;
      AVS_READ_IN || AVS_WRITE_IN |-> !AVS_WAITREQUEST_OUT;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("bus wait inserted");
   property p_unmapped;
      AVS_READ_IN && (AVS_ADDRESS_IN > jlss_pkg::ADDR_CHK || AVS_ADDRESS_IN[1:0] != 2'h0)
         |-> AVS_READDATA_OUT == jlss_pkg::UNMAPPED_VAL;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read value wrong");
endmodule // jlss_top_checker
bind jlss_top jlss_top_checker #(.FRAME_CYCLES(FRAME_CYCLES)) jlss_top_checker_inst (
   .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .SYNC_N_IN(SYNC_N_IN), .SYSREF_IN(SYSREF_IN),
   .LANE_VALID_OUT(LANE_VALID_OUT), .LANE_READY_IN(LANE_READY_IN),
   .LANE_DATA_OUT(LANE_DATA_OUT), .LANE_K_OUT(LANE_K_OUT),
   .FRAME_START_OUT(FRAME_START_OUT), .MFRAME_START_OUT(MFRAME_START_OUT),
   .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
   .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
   .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT));
`default_nettype wire

// *** sim/jlss_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Receiver stand-in: asks for a resync and releases after a run of commas.
module jlss_rx_model #(
   parameter int KMIN = 4
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // Test controls
   input wire logic resync_in,
   input wire logic stall_in,
   // Lane from the transmitter
   input wire logic lane_valid_in,
   input wire logic [7:0] lane_data_in,
   input wire logic lane_k_in,
   output logic lane_ready_out,
   // Request line back to the transmitter
   output var logic sync_n_out
);
   int k_run_r;
   // A stall withholds ready; the transmitter must keep its word meanwhile.
   assign lane_ready_out = !stall_in;
   // The request stays low until KMIN consecutive commas; KMIN defaults to four.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync_n_out <= 1'b1;
         k_run_r <= 0;
      end else if (resync_in) begin
         sync_n_out <= 1'b0;
         k_run_r <= 0;
      end else if (!sync_n_out && lane_valid_in && !stall_in) begin
         k_run_r <= (lane_k_in && lane_data_in == 8'hbc) ? k_run_r + 1 : 0;
         if (lane_k_in && k_run_r + 1 >= KMIN) begin
            sync_n_out <= 1'b1;
         end
      end
   end
endmodule // jlss_rx_model
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   // One frame size is shared by transmitter and checker; the receiver model takes only KMIN.
   localparam int FC = 4;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] ids;
      logic [31:0] sum;
   } jlss_row_t;
   // Control word, identifiers and the checksum that pair must give.
   jlss_row_t rows [4] = '{
      '{32'h00010301, 32'h000000ff, 32'h25},
      '{32'h00ff1f24, 32'h00000f00, 32'h51},
      '{32'h00020015, 32'h00000a5c, 32'h89},
      '{32'h00040314, 32'h00000000, 32'h25}};
   logic clk = 1'b0;
   logic nrst_n = 1'b0;
   logic take_s = 1'b0;
   logic sysref = 1'b0;
   logic s_valid = 1'b0;
   logic [7:0] s_data = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic resync = 1'b0;
   logic stall = 1'b0;
   logic seen = 1'b0;
   logic sync_n, s_ready, l_valid, l_ready, l_k, fs, mfs, wreq;
   logic [7:0] l_data, prev;
   logic [31:0] rdata, q;
   int fail_count = 0;
   int num_checks = 0;
   int g;
   always #50 clk = ~clk;
   jlss_top #(.FRAME_CYCLES(FC)) jlss_top_inst (.CLOCK_IN(clk), .NRST_IN(nrst_n),
      .SYNC_N_IN(sync_n), .SYSREF_IN(sysref), .SAMPLE_VALID_IN(s_valid),
      .SAMPLE_READY_OUT(s_ready), .SAMPLE_DATA_IN(s_data), .LANE_VALID_OUT(l_valid),
      .LANE_READY_IN(l_ready), .LANE_DATA_OUT(l_data), .LANE_K_OUT(l_k),
      .FRAME_START_OUT(fs), .MFRAME_START_OUT(mfs), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
      .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq));
   jlss_rx_model #(.KMIN(24)) jlss_rx_model_inst (.clk_in(clk), .nrst_in(nrst_n),
      .resync_in(resync), .stall_in(stall), .lane_valid_in(l_valid), .lane_data_in(l_data),
      .lane_k_in(l_k), .lane_ready_out(l_ready), .sync_n_out(sync_n));
   // Counting samples make any lost or repeated lane octet visible.
   // Handshakes are looked at mid cycle, where they have settled.
   always @(posedge clk) begin
      if (take_s) s_data <= s_data + 8'h01;
   end
   always @(negedge clk) begin
      take_s = s_valid && s_ready;
      if (l_valid && l_ready && !l_k) begin
         if (seen) chk("lane_order", {24'h0, prev + 8'h01}, {24'h0, l_data});
         prev = l_data;
         seen = 1'b1;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
      num_checks++;
      if (v !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, v);
      end
   endtask
   // One bus cycle; the request is held until waitrequest is seen low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, q & m);
   endtask
   // Polls the link state; two cycles per poll bounds the wait.
   task automatic wait_state(input logic [31:0] s);
      for (int t = 0; t < 100; t++) begin
         bus(1'b0, jlss_pkg::ADDR_STATUS, 32'h0);
         if ((q & 32'hf) === s) break;
      end
      chk("link_state", s, q & 32'hf);
   endtask
   task automatic resync_link();
      @(posedge clk);
      resync <= 1'b1;
      @(posedge clk);
      resync <= 1'b0;
      for (int t = 0; t < 400 && sync_n !== 1'b1; t++) @(posedge clk);
   endtask
   // Raises the reference pulse on a frame marker, counts cycles to the next.
   task automatic pulse_gap(output int n);
      for (n = 0; fs !== 1'b1 && n < 99; n++) @(posedge clk);
      sysref <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (fs !== 1'b1 && n < 99);
      sysref <= 1'b0;
   endtask
   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #3000000;
      fail_count++;
      stop_test();
   end
   initial begin
      nrst_n <= 1'b0;
      repeat (10) @(posedge clk);
      nrst_n <= 1'b1;
      s_valid <= 1'b1;
      rd_chk("state_reset", jlss_pkg::ADDR_STATUS, 32'hf, 32'h2);
      rd_chk("ctrl_reset", jlss_pkg::ADDR_CTRL, 32'h00ff1f77, 32'h00041f14);
      rd_chk("ids_reset", jlss_pkg::ADDR_IDS, 32'hfff, 32'h0);
      rd_chk("sum_reset", jlss_pkg::ADDR_CHK, 32'hff, 32'h41);
      foreach (rows[n]) begin
         bus(1'b1, jlss_pkg::ADDR_CTRL, rows[n].ctrl);
         bus(1'b1, jlss_pkg::ADDR_IDS, rows[n].ids);
         rd_chk("ctrl", jlss_pkg::ADDR_CTRL, 32'h00ff1f77, rows[n].ctrl);
         rd_chk("ids", jlss_pkg::ADDR_IDS, 32'hfff, rows[n].ids);
         rd_chk("sum", jlss_pkg::ADDR_CHK, 32'hff, rows[n].sum);
      end
      bus(1'b1, 8'h20, 32'hffffffff);
      rd_chk("unmapped", 8'h20, 32'hffffffff, jlss_pkg::UNMAPPED_VAL);
      rd_chk("ctrl_kept", jlss_pkg::ADDR_CTRL, 32'h00ff1f77, 32'h00040314);
      pulse_gap(g);
      resync_link();
      wait_state(32'h1);
      stall <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk("ready_in_stall", 32'h0, {31'h0, s_ready});
      @(posedge clk);
      stall <= 1'b0;
      bus(1'b1, jlss_pkg::ADDR_CTRL, 32'h00040324);
      resync_link();
      wait_state(32'h1);
      bus(1'b1, jlss_pkg::ADDR_CTRL, 32'h00040304);
      pulse_gap(g);
      chk("gap_sub0", FC, g);
      bus(1'b1, jlss_pkg::ADDR_CTRL, 32'h00020316);
      pulse_gap(g);
      chk("gap_first_pulse", FC, g);
      rd_chk("armed", jlss_pkg::ADDR_STATUS, 32'h80, 32'h80);
      pulse_gap(g);
      repeat (8) @(posedge clk);
      rd_chk("disarmed", jlss_pkg::ADDR_STATUS, 32'h80, 32'h0);
      pulse_gap(g);
      repeat (12 * FC * 2) @(posedge clk);
      rd_chk("timed_out", jlss_pkg::ADDR_STATUS, 32'h80, 32'h0);
      stop_test();
   end
endmodule // tb
`default_nettype wire
